// ==== rtl/acr_cfg.svh ====
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// Register offsets
`define ACR_ADDR_SEL     8'h05
`define ACR_ADDR_MODES   8'h08
`define ACR_ADDR_CLK     8'h09
`define ACR_ADDR_PAT     8'h0D
`define ACR_ADDR_FMT     8'h14
`define ACR_ADDR_COMMIT  8'hFF

// Reset values
`define ACR_RST_SEL      6'h0F
`define ACR_RST_MODES    8'h00
`define ACR_RST_CLK      8'h01
`define ACR_RST_PAT      8'h00
`define ACR_RST_FMT      8'h00

// Field positions, target indices and format code
`define ACR_SEL_MSB      5
`define ACR_BIT_COMMIT   0
`define ACR_BIT_DCS      0
`define ACR_BIT_PN23_RST 5
`define ACR_BIT_PN9_RST  4
`define ACR_BIT_LOWPWR   6
`define ACR_BIT_INVERT   2
`define ACR_IDX_WORD_MRK 4
`define ACR_IDX_BIT_CLK  5
`define ACR_FMT_TWOS     2'h1

// Pseudorandom generator seeds
`define ACR_PN9_SEED     9'h1FF
`define ACR_PN23_SEED    23'h7FFFFF

`endif

// ==== rtl/acr_pkg.sv ====
package acr_pkg;

  // Output test mode codes, low nibble of the pattern register
  typedef enum logic [3:0] {
    TM_OFF      = 4'h0,
    TM_MID      = 4'h1,
    TM_PFS      = 4'h2,
    TM_CHECK    = 4'h4,
    TM_PN23     = 4'h5,
    TM_PN9      = 4'h6,
    TM_WORD_TGL = 4'h7,
    TM_USER     = 4'h8,
    TM_BIT_TGL  = 4'h9,
    TM_SYNC     = 4'hA,
    TM_ONE_HIGH = 4'hB,
    TM_MIXED    = 4'hC
  } acr_test_mode_t;

  // Per-target configuration: pattern select and output format
  typedef struct packed {
    logic [7:0] pattern;
    logic [7:0] format;
  } acr_chan_cfg_t;

  // One register access from the serial-port front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acr_reg_req_t;

endpackage

// ==== rtl/acr_pattern_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "acr_cfg.svh"

module acr_pattern_gen #(
  parameter int W = 10
) (
  input  wire logic                  clk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  ce_in,
  input  wire logic [W-1:0]          sample_in,
  input  wire acr_pkg::acr_chan_cfg_t cfg_in,
  input  wire logic [W-1:0]          user_pattern_in,
  output var  logic [W-1:0]          data_out
);
  import acr_pkg::*;

  logic [8:0]     pn9_q;
  logic [22:0]    pn23_q;
  logic           tgl_q;
  logic [W-1:0]   raw;
  logic [W-1:0]   alt_w;
  logic [W-1:0]   sync_w;
  logic [W-1:0]   mixed_w;
  logic [26:0]    pn9_rep;
  acr_test_mode_t mode;

  assign mode    = acr_test_mode_t'(cfg_in.pattern[3:0]);
  assign pn9_rep = {3{pn9_q}};

  // Fixed words built per bit so they scale with W
  for (genvar g = 0; g < W; g++) begin : g_words
    assign alt_w[g]   = (g % 2 == 1);
    assign sync_w[g]  = (g >= W / 2);
    assign mixed_w[g] = ((g / 2) % 2 == 1);
  end

  // Offset-binary word recoded as the converter output would be
  function automatic logic [W-1:0] fmt_apply(input logic [W-1:0] w,
                                             input logic [7:0]   f);
    logic [W-1:0] r;
    r = w;
    if (f[1:0] == `ACR_FMT_TWOS) begin
      r[W-1] = ~r[W-1];
    end
    if (f[`ACR_BIT_INVERT]) begin
      r = ~r;
    end
    return r;
  endfunction

  // Short generator, held at seed while its reset bit is set
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pn9_q <= `ACR_PN9_SEED;
    end else if (ce_in) begin
      if (cfg_in.pattern[`ACR_BIT_PN9_RST]) begin
        pn9_q <= `ACR_PN9_SEED;
      end else begin
        pn9_q <= {pn9_q[7:0], pn9_q[8] ^ pn9_q[4]};
      end
    end
  end

  // Long generator, same hold behaviour
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pn23_q <= `ACR_PN23_SEED;
    end else if (ce_in) begin
      if (cfg_in.pattern[`ACR_BIT_PN23_RST]) begin
        pn23_q <= `ACR_PN23_SEED;
      end else begin
        pn23_q <= {pn23_q[21:0], pn23_q[22] ^ pn23_q[17]};
      end
    end
  end

  // Word-rate toggle for alternating patterns
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tgl_q <= 1'b0;
    end else if (ce_in) begin
      tgl_q <= ~tgl_q;
    end
  end

  // Pattern source; undefined codes fall back to live samples
  always_comb begin
    unique case (mode)
      TM_OFF:      raw = sample_in;
      TM_MID:      raw = {1'b1, {(W-1){1'b0}}};
      TM_PFS:      raw = {W{1'b1}};
      TM_CHECK:    raw = tgl_q ? ~alt_w : alt_w;
      TM_PN23:     raw = pn23_q[W-1:0];
      TM_PN9:      raw = pn9_rep[W-1:0];
      TM_WORD_TGL: raw = {W{tgl_q}};
      TM_USER:     raw = user_pattern_in;
      TM_BIT_TGL:  raw = alt_w;
      TM_SYNC:     raw = sync_w;
      TM_ONE_HIGH: raw = {{(W-1){1'b0}}, 1'b1};
      TM_MIXED:    raw = mixed_w;
      default:     raw = sample_in;
    endcase
  end

  // Test words pass the same formatter as real samples
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_out <= '0;
    end else if (ce_in) begin
      data_out <= fmt_apply(raw, cfg_in.format);
    end
  end

  a_normal_pass: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && cfg_in.pattern[3:0] == 4'h0 && cfg_in.format == 8'h00
    |=> data_out == $past(sample_in))
    else $error("normal data not passed");

  a_midscale_word: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && cfg_in.pattern[3:0] == 4'h1 && cfg_in.format == 8'h00
    |=> data_out == {1'b1, {(W-1){1'b0}}})
    else $error("midscale word wrong");

  a_twos_format: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && cfg_in.pattern[3:0] == 4'h1 && cfg_in.format == 8'h01
    |=> data_out == '0)
    else $error("pattern not recoded to twos complement");

  a_invert_data: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && cfg_in.pattern[3:0] == 4'h2 && cfg_in.format == 8'h04
    |=> data_out == '0)
    else $error("inverted full scale wrong");

  a_pn9_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ce_in && cfg_in.pattern[`ACR_BIT_PN9_RST] |=> pn9_q == 9'h1FF)
    else $error("short generator not held at seed");

endmodule
`default_nettype wire

// ==== rtl/acr_config_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "acr_cfg.svh"

module acr_config_bank #(
  parameter int W = 10
) (
  input  wire logic                        clk_in,
  input  wire logic                        resetn_in,
  input  wire logic                        ce_in,
  input  wire acr_pkg::acr_reg_req_t       reg_req_in,
  output var  logic [7:0]                  reg_rdata_out,
  output var  logic                        commit_strobe_out,
  input  wire logic [3:0][W-1:0]           sample_in,
  input  wire logic [W-1:0]                user_pattern_in,
  output wire logic [3:0][W-1:0]           data_out,
  output wire logic                        dcs_enable_out,
  output wire logic [2:0]                  op_mode_out,
  output wire logic [5:0]                  lowpower_out,
  output wire logic                        bit_clock_invert_out,
  output wire logic                        word_marker_invert_out
);
  import acr_pkg::*;

  localparam int NT = 6; // Four data channels, word marker, bit clock

  logic [5:0]    sel_q;
  logic [7:0]    stg_mode_q;
  logic [7:0]    act_mode_q;
  logic [7:0]    stg_clk_q;
  logic [7:0]    act_clk_q;
  acr_chan_cfg_t stg_q [NT];
  acr_chan_cfg_t act_q [NT];
  logic          wr_en;
  logic          commit_hit;

  assign wr_en      = ce_in && reg_req_in.wr;
  assign commit_hit = wr_en && reg_req_in.addr == `ACR_ADDR_COMMIT
                      && reg_req_in.wdata[`ACR_BIT_COMMIT];

  // Lowest selected target answers per-target reads
  function automatic logic [2:0] first_target(input logic [5:0] s);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NT - 1; i >= 0; i--) begin
      if (s[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // Channel select acts at once; it must steer the very next write
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sel_q <= `ACR_RST_SEL;
    end else if (wr_en && reg_req_in.addr == `ACR_ADDR_SEL) begin
      sel_q <= reg_req_in.wdata[`ACR_SEL_MSB:0];
    end
  end

  // Global staging copies
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stg_mode_q <= `ACR_RST_MODES;
      stg_clk_q  <= `ACR_RST_CLK;
    end else if (wr_en) begin
      if (reg_req_in.addr == `ACR_ADDR_MODES) begin
        stg_mode_q <= reg_req_in.wdata;
      end
      if (reg_req_in.addr == `ACR_ADDR_CLK) begin
        stg_clk_q <= reg_req_in.wdata;
      end
    end
  end

  // Global active copies, loaded only by a commit
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      act_mode_q <= `ACR_RST_MODES;
      act_clk_q  <= `ACR_RST_CLK;
    end else if (commit_hit) begin
      act_mode_q <= stg_mode_q;
      act_clk_q  <= stg_clk_q;
    end
  end

  // Per-target staging and active copies
  for (genvar g = 0; g < NT; g++) begin : g_tgt
    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        stg_q[g] <= '{pattern: `ACR_RST_PAT, format: `ACR_RST_FMT};
      end else if (wr_en && sel_q[g]) begin
        if (reg_req_in.addr == `ACR_ADDR_PAT) begin
          stg_q[g].pattern <= reg_req_in.wdata;
        end
        if (reg_req_in.addr == `ACR_ADDR_FMT) begin
          stg_q[g].format <= reg_req_in.wdata;
        end
      end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        act_q[g] <= '{pattern: `ACR_RST_PAT, format: `ACR_RST_FMT};
      end else if (commit_hit) begin
        act_q[g] <= stg_q[g];
      end
    end

    assign lowpower_out[g] = act_q[g].format[`ACR_BIT_LOWPWR];
  end

  // Commit bit self-clears; the strobe marks the one transfer cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      commit_strobe_out <= 1'b0;
    end else if (ce_in) begin
      commit_strobe_out <= commit_hit;
    end
  end

  // Readback shows staged values, so software sees what it wrote
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (ce_in && reg_req_in.rd) begin
      case (reg_req_in.addr)
        `ACR_ADDR_SEL:   reg_rdata_out <= {2'h0, sel_q};
        `ACR_ADDR_MODES: reg_rdata_out <= stg_mode_q;
        `ACR_ADDR_CLK:   reg_rdata_out <= stg_clk_q;
        `ACR_ADDR_PAT:   reg_rdata_out <= stg_q[first_target(sel_q)].pattern;
        `ACR_ADDR_FMT:   reg_rdata_out <= stg_q[first_target(sel_q)].format;
        default:         reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // Active settings drive the converter controls
  assign dcs_enable_out = act_clk_q[`ACR_BIT_DCS];
  assign op_mode_out    = act_mode_q[2:0];
  assign bit_clock_invert_out =
    act_q[`ACR_IDX_BIT_CLK].format[`ACR_BIT_INVERT];
  assign word_marker_invert_out =
    act_q[`ACR_IDX_WORD_MRK].format[`ACR_BIT_INVERT];

  // One pattern generator and formatter per data channel
  for (genvar c = 0; c < 4; c++) begin : g_chan
    acr_pattern_gen #(
      .W (W)
    ) u_gen (
      .clk_in          (clk_in),
      .resetn_in       (resetn_in),
      .ce_in           (ce_in),
      .sample_in       (sample_in[c]),
      .cfg_in          (act_q[c]),
      .user_pattern_in (user_pattern_in),
      .data_out        (data_out[c])
    );
  end

  a_commit_copy: assert property (@(posedge clk_in) disable iff (!resetn_in)
    commit_hit |=> act_q[0] == $past(stg_q[0])
                   && act_q[5] == $past(stg_q[5])
                   && act_clk_q == $past(stg_clk_q))
    else $error("commit did not copy staging");

  a_commit_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !commit_hit |=> $stable(act_q[1]) && $stable(act_mode_q))
    else $error("active value moved without commit");

  a_sel_steer: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_en && reg_req_in.addr == 8'h0D && !sel_q[2] |=> $stable(stg_q[2]))
    else $error("unselected channel was written");

  a_dco_steer: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_en && reg_req_in.addr == 8'h14 && sel_q[5]
    |=> stg_q[5].format == $past(reg_req_in.wdata))
    else $error("bit clock target missed write");

  a_dcs_follow: assert property (@(posedge clk_in) disable iff (!resetn_in)
    commit_hit && stg_clk_q[0] != dcs_enable_out
    |=> dcs_enable_out != $past(dcs_enable_out))
    else $error("stabilizer enable did not follow commit");

endmodule
`default_nettype wire

// ==== verif/acr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Serial-port host: one byte access at a time on the register port
module acr_host_model (
  input  wire logic                  clk_in,
  input  wire logic [7:0]            rdata_in,
  output var  logic                  ce_out,
  output var  acr_pkg::acr_reg_req_t req_out
);
  import acr_pkg::*;
  logic [7:0] rd_q;
  // Idle until the bench starts asking
  initial begin
    ce_out  = 1'h1;
    req_out = '0;
  end
  // Held from one edge to the next; released lines show inverted data
  task automatic access(input logic w, input logic [7:0] a, d);
    @(posedge clk_in);
    req_out <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_in);
    req_out <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
    #1 rd_q = rdata_in;
  endtask
  // Clock enable moves only just after an edge, like the request lines
  task automatic hold_ce(input logic v);
    @(posedge clk_in);
    ce_out <= v;
  endtask
  // Ends every configuration sequence
  task automatic commit();
    access(1'h1, 8'hFF, 8'h01);
  endtask
endmodule
`default_nettype wire

// ==== verif/test_acr_config_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_acr_config_bank;
  import acr_pkg::*;
  localparam int W = 10;
  logic              clk_in = 1'h0;
  logic              resetn_in = 1'h0;
  logic              ce_in;
  acr_reg_req_t      req;
  logic [7:0]        rdata;
  logic              strobe;
  logic [3:0][W-1:0] sample = '0;
  logic [W-1:0]      user = '0;
  logic [3:0][W-1:0] dout;
  logic              dcs;
  logic [2:0]        opm;
  logic [5:0]        lp;
  logic              bc_inv;
  logic              wm_inv;
  logic [W-1:0]      d0;
  logic [7:0]        c;
  logic [7:0]        f;
  logic [7:0]        codes [12] = '{8'h01, 8'h02, 8'h08, 8'h09, 8'h0A,
    8'h0B, 8'h0C, 8'h04, 8'h07, 8'h25, 8'h16, 8'h00};
  int                error_cnt = 0;
  int                samples_checked = 0;

  acr_config_bank #(.W(W)) i_acr_config_bank (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .reg_req_in(req), .reg_rdata_out(rdata), .commit_strobe_out(strobe),
    .sample_in(sample), .user_pattern_in(user), .data_out(dout),
    .dcs_enable_out(dcs), .op_mode_out(opm), .lowpower_out(lp),
    .bit_clock_invert_out(bc_inv), .word_marker_invert_out(wm_inv));

  acr_host_model i_acr_host_model (
    .clk_in(clk_in), .rdata_in(rdata), .ce_out(ce_in), .req_out(req));

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_acr_host_model.access(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_acr_host_model.access(1'h0, a, 8'h00);
    check(i_acr_host_model.rd_q, e);
  endtask

  // Registered outputs need a couple of edges after a commit
  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  // Offset binary in; twos flips the MSB, invert applies last
  function automatic logic [W-1:0] fmt(input logic [W-1:0] v,
                                       input logic [7:0] fm);
    if (fm[1:0] == 2'h1) v[W-1] = ~v[W-1];
    if (fm[2]) v = ~v;
    return v;
  endfunction

  function automatic logic [W-1:0] pat(input logic [3:0] code,
                                       input int         ch);
    case (code)
      4'h1: return 10'h200;
      4'h2: return 10'h3FF;
      4'h8: return user;
      4'h9: return 10'h2AA;
      4'hA: return 10'h3E0;
      4'hB: return 10'h001;
      4'hC: return 10'h0CC;
      default: return sample[ch];
    endcase
  endfunction

  // Main sequence
  initial begin
    void'($urandom(70204));
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'h1;
    rd(8'h05, 8'h0F);
    rd(8'h09, 8'h01);
    rd(8'h14, 8'h00);
    rd(8'h0D, 8'h00);
    rd(8'h33, 8'h00);
    check(dcs, 1'h1);
    // Staged value must not act before the commit
    wr(8'h09, 8'h00);
    check(dcs, 1'h1);
    i_acr_host_model.commit();
    check(strobe, 1'h1);
    check(dcs, 1'h0);
    i_acr_host_model.hold_ce(1'h0);
    wr(8'h08, 8'h05);
    check(strobe, 1'h0);
    i_acr_host_model.hold_ce(1'h1);
    rd(8'h08, 8'h00);
    wr(8'h08, 8'h05);
    wr(8'h09, 8'h01);
    i_acr_host_model.commit();
    check(opm, 3'h5);
    check(dcs, 1'h1);
    // Every test code under a random output format
    foreach (codes[i]) begin
      c = codes[i];
      // First two formats fixed to reach the twos and invert corners
      f = (i == 0) ? 8'h01 : (i == 1) ? 8'h04 : 8'($urandom) & 8'h47;
      @(posedge clk_in);
      sample <= 40'({$urandom, $urandom});
      user <= 10'($urandom);
      wr(8'h0D, c);
      wr(8'h14, f);
      i_acr_host_model.commit();
      settle();
      d0 = dout[0];
      @(posedge clk_in);
      #1;
      check(lp, {2'h0, {4{f[6]}}});
      if (c == 8'h04 || c == 8'h07)
        check(d0 ^ dout[0], 10'h3FF);
      else if (c[7:4] != 4'h0) begin
        check(dout[0], d0);
        check(dout[0], fmt(10'h3FF, f));
      end else begin
        for (int k = 0; k < 4; k++)
          check(dout[k], fmt(pat(c[3:0], k), f));
      end
    end
    // Only channel A selected
    wr(8'h05, 8'h01);
    wr(8'h0D, 8'h01);
    i_acr_host_model.commit();
    settle();
    check(dout[0], fmt(10'h200, f));
    check(dout[1], fmt(sample[1], f));
    rd(8'h0D, 8'h01);
    // Bit clock target only
    wr(8'h05, 8'h20);
    wr(8'h14, 8'h44);
    i_acr_host_model.commit();
    settle();
    rd(8'h05, 8'h20);
    check({bc_inv, wm_inv, lp[5]}, 3'h5);
    check(lp[0], f[6]);
    summarize();
  end

  // Watchdog well beyond the expected run
  initial begin
    #100us;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
